// File: inc/box_defines.svh
// Constants for the clipper box and window remap block
`ifndef BOX_DEFINES_SVH
`define BOX_DEFINES_SVH
`define COORD_W      20
`define MEM_W        36
`define HALF_W       18
`define ADDR_W       18
`define PAIR_RESET   40'h00000_00000
`endif

// File: inc/box_pkg.sv
// Types shared by the box sequencer and the clipper end
package box_pkg;
	typedef enum logic [3:0] {
		OP_NONE,
		OP_SET_POINT_ABS,
		OP_CLIP_LOAD_ABS,
		OP_CLIP_LOAD_REL,
		OP_CLIP_LOAD_SIZE_ABS,
		OP_CLIP_LOAD_SIZE_REL,
		OP_BOX_ABS,
		OP_BOX_REL,
		OP_BOX_SIZE_ABS,
		OP_BOX_SIZE_REL
	} op_t;
	typedef enum logic [1:0] {
		REG_WINDOW,
		REG_VIEWPORT,
		REG_INSTANCE
	} rect_sel_t;
endpackage

// File: inc/box_if.sv
// Instruction link between the channel sequencer and the clipper box end
`timescale 1ns/100ps
`include "box_defines.svh"
interface box_if;
	logic                  reqValid;
	logic                  reqReady;
	box_pkg::op_t          reqOp;
	box_pkg::rect_sel_t    reqReg;
	logic                  reqIndirect;
	logic [`ADDR_W-1:0]    reqAddr;
	logic [`MEM_W-1:0]     reqWord;
	logic                  done;
	logic [`ADDR_W-1:0]    usedAddr;
	logic                  overlapFlag;
	logic                  mode2d;
	modport device (
		input  reqValid, reqOp, reqReg, reqIndirect, reqAddr, reqWord, mode2d,
		output reqReady, done, usedAddr, overlapFlag
	);
	modport host (
		output reqValid, reqOp, reqReg, reqIndirect, reqAddr, reqWord, mode2d,
		input  reqReady, done, usedAddr, overlapFlag
	);
endinterface

// File: core/clipper_box.sv
// Clipper end: current point, window, viewport, instance, box remap
`timescale 1ns/100ps
`include "box_defines.svh"
// How it works
// - Box draws nothing, only rewrites window, viewport
// - Overlap result shown as one status bit
// - New viewport maps overlap through old mapping
// - New window is master part over overlap
// - Indirect marker takes running address register
// - Absolute box: current point to fetched pair
// - Relative box: point to point plus pair
// - Size-absolute box centred on origin, negated corner
// - Box only accepted in 2D mode
// - No box mode; plain register state afterward
// - Flag compares window with last loaded register
// - Flag updated only on four-component loads
// - Absolute/relative load: left-bottom from current point
// - Set point absolute writes current point
// - Size loads update flag without set point
// - Program tests flag, skips box when clear
// - Program saves window, viewport before boxing
// - Program loads window before instance
// - 18-bit halves sign-extended to 20 bits
module clipper_box (
	input  wire logic         clk,
	input  wire logic         rst,
	box_if.device             link,
	input  wire logic [`ADDR_W-1:0] runningAddressReg,
	output logic [`COORD_W-1:0]     windowLeft,
	output logic [`COORD_W-1:0]     windowBottom,
	output logic [`COORD_W-1:0]     windowRight,
	output logic [`COORD_W-1:0]     windowTop,
	output logic [`COORD_W-1:0]     viewLeft,
	output logic [`COORD_W-1:0]     viewBottom,
	output logic [`COORD_W-1:0]     viewRight,
	output logic [`COORD_W-1:0]     viewTop
);
	localparam int W = `COORD_W;
	typedef logic signed [W-1:0] crd_t;
	typedef struct packed {
		crd_t x0, y0, x1, y1;
	} rect_t;
	typedef struct packed {
		crd_t   ptX, ptY;
		rect_t  win, view, instance_rect;
		logic   flag;
		logic   done;
		logic [`ADDR_W-1:0] used;
	} state_t;

	state_t s, next_s;

	// ---------------------------------------------------------------
	// Arithmetic helpers
	// ---------------------------------------------------------------
	function automatic crd_t sext(input logic [`HALF_W-1:0] h);
		sext = crd_t'({{(W-`HALF_W){h[`HALF_W-1]}}, h});
	endfunction
	function automatic crd_t cmax(input crd_t a, input crd_t b);
		cmax = (a > b) ? a : b;
	endfunction
	function automatic crd_t cmin(input crd_t a, input crd_t b);
		cmin = (a < b) ? a : b;
	endfunction
	// Overlap of two rectangles; empty when edges cross
	function automatic rect_t isect(input rect_t a, input rect_t b);
		isect.x0 = cmax(a.x0, b.x0);
		isect.y0 = cmax(a.y0, b.y0);
		isect.x1 = cmin(a.x1, b.x1);
		isect.y1 = cmin(a.y1, b.y1);
	endfunction
	function automatic logic nonEmpty(input rect_t r);
		nonEmpty = (r.x0 <= r.x1) && (r.y0 <= r.y1);
	endfunction
	// Linear map of c from span [s0,s1] onto [d0,d1]; wide intermediate
	// avoids overflow, zero-width source collapses onto d0
	function automatic crd_t remap(input crd_t c, input crd_t s0,
	                               input crd_t s1, input crd_t d0,
	                               input crd_t d1);
		logic signed [2*W+1:0] num;
		logic signed [W:0]     den;
		logic signed [2*W+1:0] q;
		num = (2*W+2)'(c - s0) * (2*W+2)'(d1 - d0);
		den = (W+1)'(s1) - (W+1)'(s0);
		q   = (den == '0) ? '0 : num / (2*W+2)'(den);
		remap = crd_t'(d0 + crd_t'(q));
	endfunction
	function automatic rect_t mapRect(input rect_t r, input rect_t src,
	                                  input rect_t dst);
		mapRect.x0 = remap(r.x0, src.x0, src.x1, dst.x0, dst.x1);
		mapRect.x1 = remap(r.x1, src.x0, src.x1, dst.x0, dst.x1);
		mapRect.y0 = remap(r.y0, src.y0, src.y1, dst.y0, dst.y1);
		mapRect.y1 = remap(r.y1, src.y0, src.y1, dst.y0, dst.y1);
	endfunction

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	// One instruction per accepted request; finishes in a single cycle
	always_comb begin
		crd_t  px, py;
		rect_t rr, master, common;
		logic  isBox;
		next_s = s;
		next_s.done = 1'b0;
		px = sext(link.reqWord[`MEM_W-1:`HALF_W]);
		py = sext(link.reqWord[`HALF_W-1:0]);
		rr = '0;
		master = '0;
		common = '0;
		isBox = 1'b0;
		if (link.reqValid) begin
			next_s.done = 1'b1;
			next_s.used = link.reqIndirect ? runningAddressReg
			                               : link.reqAddr;
			// Build the rectangle the operand describes
			case (link.reqOp)
				box_pkg::OP_CLIP_LOAD_ABS, box_pkg::OP_BOX_ABS: begin
					rr = '{s.ptX, s.ptY, px, py};
				end
				box_pkg::OP_CLIP_LOAD_REL, box_pkg::OP_BOX_REL: begin
					rr = '{s.ptX, s.ptY, crd_t'(s.ptX + px),
					       crd_t'(s.ptY + py)};
				end
				box_pkg::OP_CLIP_LOAD_SIZE_ABS,
				box_pkg::OP_BOX_SIZE_ABS: begin
					rr = '{crd_t'(-px), crd_t'(-py), px, py};
				end
				box_pkg::OP_CLIP_LOAD_SIZE_REL,
				box_pkg::OP_BOX_SIZE_REL: begin
					rr = '{crd_t'(s.ptX - px), crd_t'(s.ptY - py),
					       crd_t'(s.ptX + px),
					       crd_t'(s.ptY + py)};
				end
				default: rr = '0;
			endcase
			case (link.reqOp)
				box_pkg::OP_SET_POINT_ABS: begin
					next_s.ptX = px;
					next_s.ptY = py;
				end
				box_pkg::OP_CLIP_LOAD_ABS, box_pkg::OP_CLIP_LOAD_REL,
				box_pkg::OP_CLIP_LOAD_SIZE_ABS,
				box_pkg::OP_CLIP_LOAD_SIZE_REL: begin
					case (link.reqReg)
						box_pkg::REG_WINDOW:   next_s.win  = rr;
						box_pkg::REG_VIEWPORT: next_s.view = rr;
						default:               next_s.instance_rect = rr;
					endcase
					// New window vs. whatever was just loaded, so a window
					// load compares the window with itself
					next_s.flag = nonEmpty(isect(next_s.win, rr));
				end
				box_pkg::OP_BOX_ABS, box_pkg::OP_BOX_REL,
				box_pkg::OP_BOX_SIZE_ABS,
				box_pkg::OP_BOX_SIZE_REL: begin
					isBox = link.mode2d;
				end
				default: ;
			endcase
			// Box: only window and viewport change, no output
			if (isBox) begin
				master = rr;
				common = isect(s.instance_rect, s.win);
				next_s.view = mapRect(common, s.win, s.view);
				next_s.win  = mapRect(common, s.win, master);
			end
		end
	end

	// Single register for all state
	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign link.reqReady    = 1'b1;
	assign link.done        = s.done;
	assign link.usedAddr    = s.used;
	assign link.overlapFlag = s.flag;
	assign windowLeft   = s.win.x0;
	assign windowBottom = s.win.y0;
	assign windowRight  = s.win.x1;
	assign windowTop    = s.win.y1;
	assign viewLeft     = s.view.x0;
	assign viewBottom   = s.view.y0;
	assign viewRight    = s.view.x1;
	assign viewTop      = s.view.y1;
endmodule

// File: core/channel_box_seq.sv
// Channel end: issues decoded clipper and box instructions one at a time
`timescale 1ns/100ps
`include "box_defines.svh"
module channel_box_seq (
	input  wire logic               clk,
	input  wire logic               rst,
	box_if.host                     link,
	input  wire logic               cmdValid,
	input  wire box_pkg::op_t       cmdOp,
	input  wire box_pkg::rect_sel_t cmdReg,
	input  wire logic               cmdIndirect,
	input  wire logic [`ADDR_W-1:0] cmdAddr,
	input  wire logic [`MEM_W-1:0]  cmdWord,
	input  wire logic               mode2d,
	output logic                    cmdReady,
	output logic                    cmdDone,
	output logic                    overlap
);
	typedef enum logic [1:0] { IDLE, ISSUE, WAIT } seq_t;
	typedef struct packed {
		seq_t               st;
		box_pkg::op_t       op;
		box_pkg::rect_sel_t rsel;
		logic               ind;
		logic [`ADDR_W-1:0] addr;
		logic [`MEM_W-1:0]  word;
		logic               m2d;
		logic               ready;
		logic               done;
		logic               flag;
	} state_t;

	state_t s, next_s;

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	// Mode is captured with the command; the clipper ignores a box outside 2D
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		case (s.st)
			IDLE: begin
				next_s.ready = 1'b1;
				if (cmdValid && s.ready) begin
					next_s.op    = cmdOp;
					next_s.rsel  = cmdReg;
					next_s.ind   = cmdIndirect;
					next_s.addr  = cmdAddr;
					next_s.word  = cmdWord;
					next_s.m2d   = mode2d;
					next_s.ready = 1'b0;
					next_s.st    = ISSUE;
				end
			end
			ISSUE: begin
				if (link.reqReady) begin
					next_s.st = WAIT;
				end
			end
			WAIT: begin
				if (link.done) begin
					next_s.flag  = link.overlapFlag;
					next_s.done  = 1'b1;
					next_s.ready = 1'b1;
					next_s.st    = IDLE;
				end
			end
			default: next_s.st = IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign link.reqValid    = (s.st == ISSUE);
	assign link.reqOp       = s.op;
	assign link.reqReg      = s.rsel;
	assign link.reqIndirect = s.ind;
	assign link.reqAddr     = s.addr;
	assign link.reqWord     = s.word;
	assign link.mode2d      = s.m2d;
	assign cmdReady = s.ready;
	assign cmdDone  = s.done;
	assign overlap  = s.flag;
endmodule

// File: sim/clipper_box_window_remap_assertions.sv
// Checker on the link between the channel sequencer and the clipper end
`timescale 1ns/100ps
`include "box_defines.svh"
module clipper_box_window_remap_assertions (
	input wire logic               clk,
	input wire logic               rst,
	input wire logic               reqValid,
	input wire box_pkg::op_t       reqOp,
	input wire box_pkg::rect_sel_t reqReg,
	input wire logic               reqIndirect,
	input wire logic [`ADDR_W-1:0] reqAddr,
	input wire logic [`MEM_W-1:0]  reqWord,
	input wire logic               done,
	input wire logic [`ADDR_W-1:0] usedAddr,
	input wire logic               overlapFlag,
	input wire logic               mode2d
);
	logic isBox;
	logic winLoad;
	// Box ops sit at the tail of the op enum
	assign isBox = reqValid && reqOp >= box_pkg::OP_BOX_ABS;
	assign winLoad = reqValid && reqReg == box_pkg::REG_WINDOW
		&& reqOp == box_pkg::OP_CLIP_LOAD_SIZE_ABS;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ------------------------------------------------------------
	// Link timing, used address and overlap flag
	// ------------------------------------------------------------
	property p_doneAfter; reqValid |=> done; endproperty
	a_doneAfter: assert property (p_doneAfter) else $error("no done");
	property p_doneCause; done |-> $past(reqValid); endproperty
	a_doneCause: assert property (p_doneCause) else $error("stray done");
	property p_oneAtTime; reqValid |=> !reqValid; endproperty
	a_oneAtTime: assert property (p_oneAtTime) else $error("back to back");
	property p_addr;
		reqValid && !reqIndirect && mode2d |=> usedAddr == $past(reqAddr);
	endproperty
	a_addr: assert property (p_addr) else $error("address wrong");
	property p_pointFlag;
		reqValid && reqOp == box_pkg::OP_SET_POINT_ABS |=> $stable(overlapFlag);
	endproperty
	a_pointFlag: assert property (p_pointFlag) else $error("flag moved");
	property p_boxFlag; isBox |=> done && $stable(overlapFlag); endproperty
	a_boxFlag: assert property (p_boxFlag) else $error("box moved flag");
	property p_idleFlag; !reqValid |=> $stable(overlapFlag); endproperty
	a_idleFlag: assert property (p_idleFlag) else $error("idle flag");
	// A positive half size gives a window that overlaps itself
	property p_winSelf;
		winLoad && !reqWord[35] && !reqWord[17] && reqWord[34:18] != 0
			&& reqWord[16:0] != 0 |=> overlapFlag;
	endproperty
	a_winSelf: assert property (p_winSelf) else $error("self flag");
	property p_winEmpty; winLoad && reqWord[35] && reqWord[17] |=> !overlapFlag;
	endproperty
	a_winEmpty: assert property (p_winEmpty) else $error("empty flag");
	c_box: cover property (isBox && mode2d);
	c_refused: cover property (isBox && !mode2d);
	c_indirect: cover property (reqValid && reqIndirect);
endmodule

// File: sim/clipper_box_window_remap_tb.sv
// Self-checking bench: sequencer and clipper end joined by the link
`timescale 1ns/100ps
`include "box_defines.svh"
module clipper_box_window_remap_tb;
	logic                          clk;
	logic                          rst;
	logic                          cmdValid;
	box_pkg::op_t                  cmdOp;
	box_pkg::rect_sel_t            cmdReg;
	logic                          cmdIndirect;
	logic [`ADDR_W-1:0]            cmdAddr;
	logic [`MEM_W-1:0]             cmdWord;
	logic                          mode2d;
	logic                          cmdReady;
	logic                          cmdDone;
	logic                          overlap;
	logic [`ADDR_W-1:0]            runningAddressReg;
	logic [3:0][`COORD_W-1:0]      win;
	logic [3:0][`COORD_W-1:0]      view;
	logic [79:0]                   expW [4];
	box_pkg::op_t                  op;
	int                            errors;
	int                            n_tests;
	box_if i_box_if ();
	channel_box_seq i_channel_box_seq (.clk(clk), .rst(rst), .link(i_box_if),
		.cmdValid(cmdValid), .cmdOp(cmdOp), .cmdReg(cmdReg),
		.cmdIndirect(cmdIndirect), .cmdAddr(cmdAddr), .cmdWord(cmdWord),
		.mode2d(mode2d), .cmdReady(cmdReady), .cmdDone(cmdDone),
		.overlap(overlap));
	clipper_box i_clipper_box (.clk(clk), .rst(rst), .link(i_box_if),
		.runningAddressReg(runningAddressReg), .windowLeft(win[3]),
		.windowBottom(win[2]), .windowRight(win[1]), .windowTop(win[0]),
		.viewLeft(view[3]), .viewBottom(view[2]), .viewRight(view[1]),
		.viewTop(view[0]));
	clipper_box_window_remap_assertions box_checks (.clk(clk), .rst(rst),
		.reqValid(i_box_if.reqValid), .reqOp(i_box_if.reqOp),
		.reqReg(i_box_if.reqReg), .reqIndirect(i_box_if.reqIndirect),
		.reqAddr(i_box_if.reqAddr), .reqWord(i_box_if.reqWord),
		.done(i_box_if.done), .usedAddr(i_box_if.usedAddr),
		.overlapFlag(i_box_if.overlapFlag), .mode2d(i_box_if.mode2d));
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Operand word: x in the high half, y in the low half
	function automatic logic [`MEM_W-1:0] pr(input int x, input int y);
		pr = {x[17:0], y[17:0]};
	endfunction
	function automatic logic [79:0] rc(input int l, b, r, t);
		rc = {l[19:0], b[19:0], r[19:0], t[19:0]};
	endfunction
	task automatic chk(input string nm, input logic [79:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// One command: held until taken, then wait for the done pulse
	task automatic cmd(input box_pkg::op_t o, input box_pkg::rect_sel_t rg,
		input logic ind, input logic [`MEM_W-1:0] w);
		int k;
		k = 0;
		cmdOp = o;
		cmdReg = rg;
		cmdIndirect = ind;
		cmdWord = w;
		cmdAddr = cmdAddr + 18'h00001;
		cmdValid = 1'b1;
		while (cmdReady !== 1'b1 && k < 20) begin
			@(posedge clk) #1;
			k++;
		end
		@(posedge clk) #1;
		cmdValid = 1'b0;
		while (cmdDone !== 1'b1 && k < 40) begin
			@(posedge clk) #1;
			k++;
		end
		if (k >= 40) chk("cmdDone", 80'(cmdDone), 80'h1);
		if (mode2d) chk("usedAddr", 80'(i_box_if.usedAddr),
			80'(ind ? runningAddressReg : cmdAddr));
	endtask
	task automatic ld(input box_pkg::rect_sel_t rg, input int x, input int y);
		cmd(box_pkg::OP_CLIP_LOAD_SIZE_ABS, rg, 1'b0, pr(x, y));
	endtask
	task automatic setpt(input int x, input int y);
		cmd(box_pkg::OP_SET_POINT_ABS, box_pkg::REG_WINDOW, 1'b0, pr(x, y));
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Watchdog: the sequence needs a few hundred cycles at most
	initial begin
		#100000;
		errors++;
		test_done();
	end
	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		errors = 0;
		n_tests = 0;
		rst = 1'b1;
		cmdValid = 1'b0;
		cmdOp = box_pkg::OP_NONE;
		cmdReg = box_pkg::REG_WINDOW;
		cmdIndirect = 1'b0;
		cmdAddr = 18'h00100;
		cmdWord = 36'h000000000;
		mode2d = 1'b1;
		runningAddressReg = 18'h2A5C3;
		// New windows: the overlap (-50..50 inside -100..100) carried onto
		// each master, whose spans are picked so the divisions come out even
		expW = '{rc(0, -5, 40, 25), rc(-5, -10, 25, 10),
			rc(-30, -20, 30, 20), rc(-50, -40, 10, 0)};
		repeat (8) @(posedge clk);
		#1 rst = 1'b0;
		ld(box_pkg::REG_WINDOW, -1, -1);
		chk("overlap", 80'(overlap), 80'h0);
		ld(box_pkg::REG_WINDOW, 100, 100);
		chk("overlap", 80'(overlap), 80'h1);
		chk("window", win, rc(-100, -100, 100, 100));
		setpt(-200, -200);
		cmd(box_pkg::OP_CLIP_LOAD_ABS, box_pkg::REG_VIEWPORT, 1'b0, pr(200, 200));
		chk("view", view, rc(-200, -200, 200, 200));
		setpt(500, 500);
		cmd(box_pkg::OP_CLIP_LOAD_SIZE_REL, box_pkg::REG_INSTANCE, 1'b0, pr(10, 10));
		chk("overlap", 80'(overlap), 80'h0);
		setpt(-200, -200);
		chk("overlap", 80'(overlap), 80'h0);
		cmd(box_pkg::OP_CLIP_LOAD_REL, box_pkg::REG_INSTANCE, 1'b0, pr(150, 150));
		chk("overlap", 80'(overlap), 80'h1);
		// Each box form, odd ones through the running address
		op = box_pkg::OP_BOX_ABS;
		for (int i = 0; i < 4; i++) begin
			// Reloading window and viewport restores them after each box
			ld(box_pkg::REG_WINDOW, 100, 100);
			ld(box_pkg::REG_VIEWPORT, 200, 200);
			ld(box_pkg::REG_INSTANCE, 50, 50);
			chk("overlap", 80'(overlap), 80'h1);
			setpt(-20, -20);
			cmd(op, box_pkg::REG_WINDOW, i[0], pr(60, 40));
			chk("window", win, expW[i]);
			chk("view", view, rc(-100, -100, 100, 100));
			chk("overlap", 80'(overlap), 80'h1);
			op = op.next();
		end
		// Outside 2D a box leaves the window alone
		mode2d = 1'b0;
		cmd(box_pkg::OP_BOX_SIZE_ABS, box_pkg::REG_WINDOW, 1'b0, pr(7, 7));
		chk("window", win, expW[3]);
		mode2d = 1'b1;
		test_done();
	end
endmodule
